// ==== logic/detector_sequencer.sv ====
// Cooled detector power, cooler, bias and shutter sequencer
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "sequencer_consts.svh"
// Contract
// - Enter operating: power on, go starting
// - Starting: close shutter, start cooling
// - Cold thirty-two seconds: bias on
// - Cool and hot: bias off, close
// - Settled: processing on, calibrate or open
// - Calibrate sixty-four seconds, hot aborts
// - Opening: wait open or three tries
// - Running and hot: close to cool
// - Running leakage over limit: close, anneal
// - Closing to cool: closed, then cooling
// - Recheck leakage: heat or raise baseline
// - Anneal timed, then off or restart
// - Commanded calibration: three close pulses
// - Leaving operating: bias, cooler off, close
// - Door moves with cooler disabled
// - Too many sensors disabled: close door
// - Leakage level or rate: close door
module detector_sequencer #(
	parameter int SEC_CYCLES  = `SEC_NS / `CLK_NS,
	parameter int STEP_CYCLES = `DOOR_STEP_NS / `CLK_NS
) (
	input  wire logic                        clk,
	input  wire logic                        resetn,
	input  wire logic                        op_mode,
	input  wire logic                        conv_overtemp,
	input  wire logic signed [7:0]           det_temp,
	input  wire logic [15:0]                 leakage,
	input  wire logic                        shutter_is_open,
	input  wire logic                        shutter_is_closed,
	input  wire logic                        door_cmd,
	input  wire logic                        door_cmd_open,
	input  wire logic                        door_switch,
	input  wire logic [7:0]                  disabled_sensors,
	input  wire logic [3:0]                  reg_addr,
	input  wire logic [15:0]                 reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic [15:0]                      reg_rdata,
	output sequencer_pkg::det_drive_s        det_drive,
	output sequencer_pkg::shutter_drive_s    shutter_drive,
	output logic [7:0]                       peltier_target,
	output logic                             door_step,
	output logic                             door_open_dir,
	output sequencer_pkg::seq_state_e        seq_state
);
	import sequencer_pkg::*;

	// ****************
	// Reset release
	// ****************
	logic rst_meta_r;
	logic rst_n_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// ****************
	// Declarations
	// ****************
	seq_state_e  state_r;
	logic [15:0] sec_r;
	logic [15:0] baseline_r;
	logic        power_r;
	logic        pelt_on_r;
	logic        pelt_heat_r;
	logic        bias_r;
	logic        proc_r;
	logic        mon_dis_r;
	logic        inhibit_r;
	logic        cal_req_r;
	logic        cmd_cal_r;
	logic [15:0] leak_limit_r;
	logic [15:0] anneal_inc_r;
	logic [15:0] anneal_s_r;
	logic [7:0]  pelt_tgt_r;
	logic [7:0]  door_thr_r;
	logic [15:0] lvl_thr_r;
	logic [15:0] rate_thr_r;
	logic [15:0] settle_s_r;
	logic        op_prev_r;
	logic        sh_req_r;
	logic        sh_req_open_r;
	logic        sh_req_force_r;
	logic        sh_active_r;
	logic        sh_open_r;
	logic        sh_force_r;
	logic [1:0]  sh_tries_r;
	logic [15:0] leak_prev_r;
	logic        door_start_r;
	logic        door_start_open_r;
	logic        sec_tick;
	logic        step_tick;
	logic        door_busy;
	logic        door_step_w;
	logic        door_dir_w;
	logic        door_closed;
	logic        op_now;
	logic        enter_op;
	logic        leave_op;
	logic        hot;
	logic        cold;
	logic        sh_idle;
	logic        sh_reached;
	logic        ctrl_wr;
	logic [16:0] base_plus_inc;
	logic [15:0] leak_rate;
	logic        door_auto;

	assign op_now        = op_mode & ~conv_overtemp;
	assign enter_op      = op_now & ~op_prev_r;
	assign leave_op      = op_prev_r & ~op_now;
	assign hot           = det_temp > `TEMP_HOT;
	assign cold          = det_temp < `TEMP_COLD;
	assign sh_idle       = ~sh_req_r & ~sh_active_r;
	assign sh_reached    = sh_open_r ? shutter_is_open : shutter_is_closed;
	assign ctrl_wr       = reg_wr && reg_addr == `ADDR_CTRL;
	assign base_plus_inc = {1'b0, baseline_r} + {1'b0, anneal_inc_r};
	assign leak_rate     = (leakage > leak_prev_r) ? leakage - leak_prev_r : 16'h0;

	// ****************
	// Time bases
	// ****************
	tick_gen #(.PERIOD(SEC_CYCLES)) u_sec_tick (
		.clk   (clk),
		.rst_n (rst_n_r),
		.tick  (sec_tick)
	);
	tick_gen #(.PERIOD(STEP_CYCLES)) u_step_tick (
		.clk   (clk),
		.rst_n (rst_n_r),
		.tick  (step_tick)
	);

	// ****************
	// Register writes
	// ****************
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			mon_dis_r    <= 1'b0;
			inhibit_r    <= 1'b0;
			leak_limit_r <= `RST_LEAK_LIMIT;
			anneal_inc_r <= `RST_ANNEAL_INC;
			anneal_s_r   <= `RST_ANNEAL_S;
			pelt_tgt_r   <= `RST_PELT_TGT;
			door_thr_r   <= `RST_DOOR_THR;
			lvl_thr_r    <= `RST_LVL_THR;
			rate_thr_r   <= `RST_RATE_THR;
			settle_s_r   <= `RST_SETTLE_S;
		end else if (reg_wr) begin
			unique case (reg_addr)
				`ADDR_CTRL: begin
					mon_dis_r <= reg_wdata[`CTRL_MON_DIS];
					inhibit_r <= reg_wdata[`CTRL_INHIBIT];
				end
				`ADDR_LEAK_LIMIT: leak_limit_r <= reg_wdata;
				`ADDR_ANNEAL_INC: anneal_inc_r <= reg_wdata;
				`ADDR_ANNEAL_S:   anneal_s_r   <= reg_wdata;
				`ADDR_PELT_TGT:   pelt_tgt_r   <= reg_wdata[7:0];
				`ADDR_DOOR_THR:   door_thr_r   <= reg_wdata[7:0];
				`ADDR_LVL_THR:    lvl_thr_r    <= reg_wdata;
				`ADDR_RATE_THR:   rate_thr_r   <= reg_wdata;
				`ADDR_SETTLE_S:   settle_s_r   <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Software set beats the hardware clear on entry to calibration
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			cal_req_r <= 1'b0;
			cmd_cal_r <= 1'b0;
		end else begin
			cmd_cal_r <= ctrl_wr & reg_wdata[`CTRL_CMD_CAL];
			if (ctrl_wr)
				cal_req_r <= reg_wdata[`CTRL_CAL_REQ];
			else if (state_r == ST_COOL && !hot && !leave_op && sec_r >= settle_s_r && sec_tick)
				cal_req_r <= 1'b0;
		end
	end

	// ****************
	// Register reads
	// ****************
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			reg_rdata <= 16'h0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`ADDR_CTRL:       reg_rdata <= {13'h0, cal_req_r, inhibit_r, mon_dis_r};
				`ADDR_LEAK_LIMIT: reg_rdata <= leak_limit_r;
				`ADDR_ANNEAL_INC: reg_rdata <= anneal_inc_r;
				`ADDR_ANNEAL_S:   reg_rdata <= anneal_s_r;
				`ADDR_PELT_TGT:   reg_rdata <= {8'h0, pelt_tgt_r};
				`ADDR_DOOR_THR:   reg_rdata <= {8'h0, door_thr_r};
				`ADDR_LVL_THR:    reg_rdata <= lvl_thr_r;
				`ADDR_RATE_THR:   reg_rdata <= rate_thr_r;
				`ADDR_SETTLE_S:   reg_rdata <= settle_s_r;
				`ADDR_STATUS:     reg_rdata <= {2'h0, door_closed, door_busy, sh_active_r, sh_tries_r,
					power_r, pelt_on_r, pelt_heat_r, bias_r, proc_r, state_r};
				`ADDR_BASELINE:   reg_rdata <= baseline_r;
				default:          reg_rdata <= 16'h0;
			endcase
		end else begin
			reg_rdata <= 16'h0;
		end
	end

	// ****************
	// Sequencer
	// ****************
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			state_r        <= ST_OFF;
			sec_r          <= 16'h0;
			baseline_r     <= 16'h0;
			power_r        <= 1'b0;
			pelt_on_r      <= 1'b0;
			pelt_heat_r    <= 1'b0;
			bias_r         <= 1'b0;
			proc_r         <= 1'b0;
			sh_req_r       <= 1'b0;
			sh_req_open_r  <= 1'b0;
			sh_req_force_r <= 1'b0;
		end else begin
			sh_req_r       <= 1'b0;
			sh_req_force_r <= 1'b0;
			if (sec_tick)
				sec_r <= sec_r + 16'h1;
			if (leave_op) begin
				state_r       <= ST_OFF;
				power_r       <= 1'b0;
				pelt_on_r     <= 1'b0;
				pelt_heat_r   <= 1'b0;
				bias_r        <= 1'b0;
				proc_r        <= 1'b0;
				sh_req_r      <= 1'b1;
				sh_req_open_r <= 1'b0;
			end else begin
				unique case (state_r)
					ST_OFF: begin
						if (enter_op && !mon_dis_r) begin
							power_r <= 1'b1;
							state_r <= ST_STARTING;
						end
					end
					ST_STARTING: begin
						sh_req_r      <= 1'b1;
						sh_req_open_r <= 1'b0;
						pelt_on_r     <= 1'b1;
						pelt_heat_r   <= 1'b0;
						sec_r         <= 16'h0;
						state_r       <= ST_COOLING;
					end
					ST_COOLING: begin
						if (!cold) begin
							sec_r <= 16'h0;
						end else if (sec_r >= `COLD_HOLD_S) begin
							bias_r  <= 1'b1;
							sec_r   <= 16'h0;
							state_r <= ST_COOL;
						end
					end
					ST_COOL: begin
						if (hot) begin
							bias_r        <= 1'b0;
							sh_req_r      <= 1'b1;
							sh_req_open_r <= 1'b0;
							state_r       <= ST_CLOSE_COOL;
						end else if (sec_r >= settle_s_r && sec_tick) begin
							proc_r <= 1'b1;
							sec_r  <= 16'h0;
							if (cal_req_r) begin
								state_r <= ST_CAL;
							end else begin
								sh_req_r      <= 1'b1;
								sh_req_open_r <= 1'b1;
								state_r       <= ST_OPENING;
							end
						end
					end
					ST_CAL: begin
						if (hot) begin
							bias_r        <= 1'b0;
							sh_req_r      <= 1'b1;
							sh_req_open_r <= 1'b0;
							state_r       <= ST_CLOSE_COOL;
						end else if (sec_r >= `CAL_WAIT_S) begin
							sh_req_r      <= 1'b1;
							sh_req_open_r <= 1'b1;
							state_r       <= ST_OPENING;
						end
					end
					ST_OPENING: begin
						if (hot) begin
							bias_r        <= 1'b0;
							sh_req_r      <= 1'b1;
							sh_req_open_r <= 1'b0;
							state_r       <= ST_CLOSE_COOL;
						end else if (sh_idle) begin
							state_r <= ST_RUNNING;
						end
					end
					ST_RUNNING: begin
						if (hot) begin
							sh_req_r      <= 1'b1;
							sh_req_open_r <= 1'b0;
							state_r       <= ST_CLOSE_COOL;
						end else if (leakage > leak_limit_r) begin
							sh_req_r      <= 1'b1;
							sh_req_open_r <= 1'b0;
							state_r       <= ST_CLOSE_ANNEAL;
						end else if (cmd_cal_r) begin
							sh_req_r       <= 1'b1;
							sh_req_open_r  <= 1'b0;
							sh_req_force_r <= 1'b1;
							state_r        <= ST_CMD_CAL;
						end
					end
					ST_CLOSE_COOL: begin
						if (sh_idle) begin
							sec_r   <= 16'h0;
							state_r <= ST_COOLING;
						end
					end
					ST_CLOSE_ANNEAL: begin
						if (sh_idle) begin
							sec_r   <= 16'h0;
							state_r <= ST_WAIT_ANNEAL;
						end
					end
					ST_WAIT_ANNEAL: begin
						if (sec_r >= `ANNEAL_WAIT_S) begin
							sec_r <= 16'h0;
							if ({1'b0, leakage} > base_plus_inc) begin
								pelt_heat_r <= 1'b1;
								state_r     <= ST_ANNEALING;
							end else begin
								baseline_r    <= baseline_r + leak_limit_r;
								sh_req_r      <= 1'b1;
								sh_req_open_r <= 1'b1;
								state_r       <= ST_OPENING;
							end
						end
					end
					ST_ANNEALING: begin
						if (sec_r >= anneal_s_r) begin
							pelt_heat_r <= 1'b0;
							pelt_on_r   <= 1'b0;
							if (inhibit_r) begin
								power_r <= 1'b0;
								bias_r  <= 1'b0;
								proc_r  <= 1'b0;
								state_r <= ST_OFF;
							end else begin
								state_r <= ST_STARTING;
							end
						end
					end
					ST_CMD_CAL: begin
						if (sh_idle) begin
							sec_r   <= 16'h0;
							state_r <= ST_CAL;
						end
					end
					default: state_r <= ST_OFF;
				endcase
			end
		end
	end

	// ****************
	// Shutter drive
	// ****************
	// Retries are paced by the second tick; one pulse per attempt
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			sh_active_r   <= 1'b0;
			sh_open_r     <= 1'b0;
			sh_force_r    <= 1'b0;
			sh_tries_r    <= 2'h0;
			shutter_drive <= '0;
		end else begin
			shutter_drive <= '0;
			if (sh_req_r) begin
				sh_active_r                <= 1'b1;
				sh_open_r                  <= sh_req_open_r;
				sh_force_r                 <= sh_req_force_r;
				sh_tries_r                 <= 2'h1;
				shutter_drive.open_pulse   <= sh_req_open_r;
				shutter_drive.close_pulse  <= ~sh_req_open_r;
			end else if (sh_active_r) begin
				if (sh_reached && !sh_force_r) begin
					sh_active_r <= 1'b0;
				end else if (sec_tick) begin
					if (sh_tries_r == `SHUT_TRIES) begin
						sh_active_r <= 1'b0;
					end else begin
						sh_tries_r                <= sh_tries_r + 2'h1;
						shutter_drive.open_pulse  <= sh_open_r;
						shutter_drive.close_pulse <= ~sh_open_r;
					end
				end
			end
		end
	end

	// ****************
	// Door triggers
	// ****************
	// Rate is sampled once a second, so it is a per-second slope
	assign door_auto = op_prev_r && !door_closed &&
		(disabled_sensors > door_thr_r || leakage > lvl_thr_r || leak_rate > rate_thr_r);
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			op_prev_r         <= 1'b0;
			leak_prev_r       <= 16'h0;
			door_start_r      <= 1'b0;
			door_start_open_r <= 1'b0;
		end else begin
			op_prev_r <= op_now;
			if (sec_tick)
				leak_prev_r <= leakage;
			door_start_r <= 1'b0;
			if (!door_busy && !door_start_r) begin
				if (door_cmd) begin
					door_start_r      <= 1'b1;
					door_start_open_r <= door_cmd_open;
				end else if (door_auto) begin
					door_start_r      <= 1'b1;
					door_start_open_r <= 1'b0;
				end
			end
		end
	end

	door_ctrl u_door (
		.clk        (clk),
		.rst_n      (rst_n_r),
		.start      (door_start_r),
		.start_open (door_start_open_r),
		.step_tick  (step_tick),
		.end_switch (door_switch),
		.busy       (door_busy),
		.step       (door_step_w),
		.dir_open   (door_dir_w),
		.closed     (door_closed)
	);

	// ****************
	// Output stage
	// ****************
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			det_drive      <= '0;
			peltier_target <= `RST_PELT_TGT;
			door_step      <= 1'b0;
			door_open_dir  <= 1'b0;
			seq_state      <= ST_OFF;
		end else begin
			det_drive.power             <= power_r;
			det_drive.peltier_on        <= pelt_on_r & ~door_busy;
			det_drive.peltier_heat      <= pelt_heat_r & ~door_busy;
			det_drive.high_voltage_bias <= bias_r;
			det_drive.proc_en           <= proc_r;
			peltier_target              <= pelt_tgt_r;
			door_step                   <= door_step_w;
			door_open_dir               <= door_dir_w;
			seq_state                   <= state_r;
		end
	end
endmodule : detector_sequencer

// ==== shared/sequencer_consts.svh ====
// Named constants for the detector sequencer
`ifndef SEQUENCER_CONSTS_SVH
`define SEQUENCER_CONSTS_SVH
// ****************
// Register map
// ****************
`define ADDR_CTRL       4'h0
`define ADDR_LEAK_LIMIT 4'h1
`define ADDR_ANNEAL_INC 4'h2
`define ADDR_ANNEAL_S   4'h3
`define ADDR_PELT_TGT   4'h4
`define ADDR_DOOR_THR   4'h5
`define ADDR_LVL_THR    4'h6
`define ADDR_RATE_THR   4'h7
`define ADDR_SETTLE_S   4'h8
`define ADDR_STATUS     4'h9
`define ADDR_BASELINE   4'hA
`define CTRL_MON_DIS    0
`define CTRL_INHIBIT    1
`define CTRL_CAL_REQ    2
`define CTRL_CMD_CAL    3
// ****************
// Reset values
// ****************
`define RST_LEAK_LIMIT  16'h0100
`define RST_ANNEAL_INC  16'h0080
`define RST_ANNEAL_S    16'h0E10
`define RST_PELT_TGT    8'hEC
`define RST_DOOR_THR    8'h10
`define RST_LVL_THR     16'hFFFF
`define RST_RATE_THR    16'hFFFF
`define RST_SETTLE_S    16'h0010
// ****************
// Limits and timing
// ****************
`define TEMP_COLD       8'shF6
`define TEMP_HOT        8'sh00
`define COLD_HOLD_S     16'h0020
`define CAL_WAIT_S      16'h0040
`define ANNEAL_WAIT_S   16'h0040
`define SHUT_TRIES      2'h3
`define CLK_NS          5
`define SEC_NS          1000000000
`define DOOR_STEP_NS    1000000
`define DOOR_MAX_STEPS  16'h07D0
`endif

// ==== shared/sequencer_pkg.sv ====
// Types shared by the detector sequencer
package sequencer_pkg;
	typedef enum logic [3:0] {
		ST_OFF, ST_STARTING, ST_COOLING, ST_COOL, ST_CAL, ST_OPENING,
		ST_RUNNING, ST_CLOSE_COOL, ST_CLOSE_ANNEAL, ST_WAIT_ANNEAL,
		ST_ANNEALING, ST_CMD_CAL
	} seq_state_e;
	typedef struct packed {
		logic power;
		logic peltier_on;
		logic peltier_heat;
		logic high_voltage_bias;
		logic proc_en;
	} det_drive_s;
	typedef struct packed {
		logic open_pulse;
		logic close_pulse;
	} shutter_drive_s;
endpackage : sequencer_pkg

// ==== logic/tick_gen.sv ====
// Periodic one-cycle tick generator
`timescale 1ns/1ps
module tick_gen #(
	parameter int PERIOD = 200
) (
	input  wire logic clk,
	input  wire logic rst_n,
	output logic      tick
);
	logic [31:0] cnt_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 32'h0;
			tick  <= 1'b0;
		end else if (cnt_r == 32'(PERIOD - 1)) begin
			cnt_r <= 32'h0;
			tick  <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 32'h1;
			tick  <= 1'b0;
		end
	end
endmodule : tick_gen

// ==== logic/door_ctrl.sv ====
// Door stepper with cooler interlock
`timescale 1ns/1ps
`include "sequencer_consts.svh"
module door_ctrl (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic start,
	input  wire logic start_open,
	input  wire logic step_tick,
	input  wire logic end_switch,
	output logic      busy,
	output logic      step,
	output logic      dir_open,
	output logic      closed
);
	typedef enum logic [1:0] {D_IDLE, D_PREP, D_STEP} door_st_e;
	door_st_e    st_r;
	logic [15:0] steps_r;
	// ****************
	// Door sequence
	// ****************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r     <= D_IDLE;
			steps_r  <= 16'h0;
			busy     <= 1'b0;
			step     <= 1'b0;
			dir_open <= 1'b0;
			closed   <= 1'b0;
		end else begin
			step <= 1'b0;
			unique case (st_r)
				D_IDLE: begin
					if (start) begin
						busy     <= 1'b1;
						dir_open <= start_open;
						steps_r  <= 16'h0;
						st_r     <= D_PREP;
					end
				end
				// Gives the cooler a cycle to drop before motion
				D_PREP: st_r <= D_STEP;
				D_STEP: begin
					if (end_switch || steps_r == `DOOR_MAX_STEPS) begin
						busy   <= 1'b0;
						closed <= ~dir_open;
						st_r   <= D_IDLE;
					end else if (step_tick) begin
						step    <= 1'b1;
						steps_r <= steps_r + 16'h1;
					end
				end
			endcase
		end
	end
endmodule : door_ctrl

// ==== testbench/mech_model.sv ====
// Shutter and door mechanism model
`timescale 1ns/1ps
module mech_model (
	input  wire logic                          clk,
	input  wire sequencer_pkg::shutter_drive_s shutter_drive,
	input  wire logic                          door_step,
	input  wire logic                          stuck,
	output logic                               shutter_is_open,
	output logic                               shutter_is_closed,
	output logic                               door_switch
);
	import sequencer_pkg::*;
	logic [1:0] travel_r = 2'h0;
	logic       open_r   = 1'b0;
	logic [2:0] steps_r  = 3'h0;
	// Both switches low while moving or jammed
	assign shutter_is_open   = !stuck && travel_r == 2'h0 && open_r;
	assign shutter_is_closed = !stuck && travel_r == 2'h0 && !open_r;
	assign door_switch       = steps_r == 3'h5;
	always @(posedge clk) begin
		if (shutter_drive.open_pulse || shutter_drive.close_pulse) begin
			open_r <= shutter_drive.open_pulse;
			travel_r <= 2'h3;
		end else if (travel_r != 2'h0) begin
			travel_r <= travel_r - 2'h1;
		end
	end
	// Door end switch after five steps
	always @(posedge clk) begin
		if (door_step) begin
			steps_r <= (steps_r == 3'h5) ? 3'h1 : steps_r + 3'h1;
		end
	end
endmodule : mech_model

// ==== testbench/sequencer_checker.sv ====
// Port assertions for the detector sequencer
`timescale 1ns/1ps
module sequencer_checker (
	input wire logic                          clk,
	input wire logic                          resetn,
	input wire logic                          op_mode,
	input wire logic signed [7:0]             det_temp,
	input wire logic [15:0]                   leakage,
	input wire logic                          shutter_is_open,
	input wire logic                          shutter_is_closed,
	input wire sequencer_pkg::det_drive_s     det_drive,
	input wire sequencer_pkg::shutter_drive_s shutter_drive,
	input wire sequencer_pkg::seq_state_e     seq_state
);
	import sequencer_pkg::*;
	default clocking @(posedge clk); endclocking
	a_start_power: assert property (disable iff (!resetn)
		$rose(seq_state == ST_STARTING) |-> ##[0:2] det_drive.power) else $error("power not on");
	a_start_close: assert property (disable iff (!resetn || !op_mode)
		seq_state == ST_STARTING |-> ##[1:4] shutter_drive.close_pulse ##0 det_drive.peltier_on)
		else $error("no close or cooling at start");
	a_cold_bias: assert property (disable iff (!resetn || !op_mode)
		seq_state == ST_COOLING ##1 seq_state == ST_COOL |-> ##[0:2] det_drive.high_voltage_bias)
		else $error("bias not on");
	a_hot_close: assert property (disable iff (!resetn || !op_mode)
		seq_state == ST_RUNNING && det_temp > 8'sh00 |-> ##[1:3] seq_state == ST_CLOSE_COOL)
		else $error("hot not handled");
	a_leak_anneal: assert property (disable iff (!resetn || !op_mode)
		seq_state == ST_RUNNING && leakage > 16'h0100 && det_temp <= 8'sh00
		|-> ##[1:3] seq_state == ST_CLOSE_ANNEAL) else $error("leakage not handled");
	a_open_run: assert property (disable iff (!resetn || !op_mode)
		seq_state == ST_OPENING && shutter_is_open && det_temp <= 8'sh00
		|-> ##[1:4] seq_state == ST_RUNNING) else $error("open not followed by run");
	a_closed_cool: assert property (disable iff (!resetn || !op_mode)
		seq_state == ST_CLOSE_COOL && shutter_is_closed |-> ##[1:4] seq_state == ST_COOLING)
		else $error("closed not followed by cooling");
	a_standby_off: assert property (disable iff (!resetn)
		(!op_mode)[*5] |-> !det_drive.high_voltage_bias && !det_drive.power)
		else $error("bias or power on in standby");
endmodule : sequencer_checker
bind detector_sequencer sequencer_checker chk (.clk(clk), .resetn(resetn), .op_mode(op_mode),
	.det_temp(det_temp), .leakage(leakage), .shutter_is_open(shutter_is_open),
	.shutter_is_closed(shutter_is_closed), .det_drive(det_drive), .shutter_drive(shutter_drive),
	.seq_state(seq_state));

// ==== testbench/tb.sv ====
// Bench for the detector sequencer
`timescale 1ns/1ps
`include "sequencer_consts.svh"
module tb;
	import sequencer_pkg::*;
	localparam int SEC = 20;
	logic clk = 1'b0, resetn = 1'b0, op_mode = 1'b0, conv_overtemp = 1'b0, door_cmd = 1'b0;
	logic door_cmd_open = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, stuck = 1'b0;
	logic signed [7:0] det_temp = 8'sh19;
	logic [15:0] leakage = 16'h0000, reg_wdata = 16'h0000, reg_rdata, rd_val;
	logic [7:0] disabled_sensors = 8'h00, peltier_target;
	logic [3:0] reg_addr = 4'h0;
	logic shutter_is_open, shutter_is_closed, door_switch, door_step, door_open_dir;
	det_drive_s det_drive;
	shutter_drive_s shutter_drive;
	seq_state_e seq_state;
	int failures = 0, total_checks = 0, waited, opens, closes, steps, seed = 74298;
	always #2.5 clk = ~clk;
	// Counted off the sampling edge to avoid races
	always @(negedge clk) begin
		opens += shutter_drive.open_pulse;
		closes += shutter_drive.close_pulse;
		steps += door_step;
	end
	detector_sequencer #(.SEC_CYCLES(SEC), .STEP_CYCLES(4)) dut (.clk(clk), .resetn(resetn),
		.op_mode(op_mode), .conv_overtemp(conv_overtemp), .det_temp(det_temp), .leakage(leakage),
		.shutter_is_open(shutter_is_open), .shutter_is_closed(shutter_is_closed), .door_cmd(door_cmd),
		.door_cmd_open(door_cmd_open), .door_switch(door_switch), .disabled_sensors(disabled_sensors),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .det_drive(det_drive), .shutter_drive(shutter_drive),
		.peltier_target(peltier_target), .door_step(door_step), .door_open_dir(door_open_dir),
		.seq_state(seq_state));
	mech_model mech (.clk(clk), .shutter_drive(shutter_drive), .door_step(door_step), .stuck(stuck),
		.shutter_is_open(shutter_is_open), .shutter_is_closed(shutter_is_closed),
		.door_switch(door_switch));
	task automatic finish_test();
		if (failures == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wait_st(input seq_state_e s, input int lim);
		waited = 0;
		while (seq_state !== s && waited < lim) begin
			@(posedge clk);
			waited++;
		end
		chk("state", 16'(s), 16'(seq_state));
		if (seq_state !== s) begin
			finish_test();
		end
	endtask : wait_st
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		// Lets an edge pass so back-to-back writes never drive the strobe twice at once
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		@(posedge clk);
	endtask : rd
	// Cold reading must hold a full 32 ticks
	task automatic cool_down();
		det_temp <= 8'(-11 - {$random(seed)} % 30);
		wait_st(ST_COOL, 40 * SEC);
		chk("cold hold", 16'h1, 16'(waited >= 31 * SEC));
		repeat (2) @(posedge clk);
		chk("bias", 16'h1, 16'(det_drive.high_voltage_bias));
	endtask : cool_down
	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		rd(`ADDR_LEAK_LIMIT, rd_val);
		chk("leak limit", 16'h0100, rd_val);
		rd(4'hB, rd_val);
		chk("unmapped", 16'h0000, rd_val);
		chk("target", 16'h00EC, 16'(peltier_target));
		wr(`ADDR_SETTLE_S, 16'h0001);
		wr(`ADDR_ANNEAL_S, 16'h0002);
		disabled_sensors <= 8'({$random(seed)} % 17);
		op_mode <= 1'b1;
		wait_st(ST_COOLING, 10);
		repeat (2) @(posedge clk);
		chk("power", 16'h1, 16'(det_drive.power));
		chk("cooler", 16'h1, 16'(det_drive.peltier_on));
		cool_down();
		stuck <= 1'b1;
		opens = 0;
		wait_st(ST_OPENING, 3 * SEC);
		wait_st(ST_RUNNING, 6 * SEC);
		chk("open tries", 16'h3, 16'(opens));
		chk("processing", 16'h1, 16'(det_drive.proc_en));
		stuck <= 1'b0;
		det_temp <= 8'sh05;
		wait_st(ST_CLOSE_COOL, 5);
		wait_st(ST_COOLING, 5 * SEC);
		wr(`ADDR_CTRL, 16'h0004);
		cool_down();
		wait_st(ST_CAL, 3 * SEC);
		wait_st(ST_OPENING, 70 * SEC);
		chk("cal time", 16'h1, 16'(waited >= 63 * SEC));
		wait_st(ST_RUNNING, 4 * SEC);
		leakage <= 16'h0200;
		wait_st(ST_CLOSE_ANNEAL, 5);
		wait_st(ST_WAIT_ANNEAL, 5 * SEC);
		leakage <= 16'h0050;
		wait_st(ST_OPENING, 70 * SEC);
		rd(`ADDR_BASELINE, rd_val);
		chk("baseline", 16'h0100, rd_val);
		wait_st(ST_RUNNING, 4 * SEC);
		leakage <= 16'h0181 + 16'({$random(seed)} % 16'h0E00);
		wait_st(ST_CLOSE_ANNEAL, 5);
		wait_st(ST_ANNEALING, 75 * SEC);
		repeat (2) @(posedge clk);
		chk("heating", 16'h1, 16'(det_drive.peltier_heat));
		leakage <= 16'h0000;
		wr(`ADDR_CTRL, 16'h0002);
		wait_st(ST_OFF, 4 * SEC);
		repeat (2) @(posedge clk);
		chk("power down", 16'h0, 16'(det_drive.power));
		op_mode <= 1'b0;
		repeat (2) @(posedge clk);
		op_mode <= 1'b1;
		wait_st(ST_STARTING, 5);
		cool_down();
		wait_st(ST_RUNNING, 8 * SEC);
		closes = 0;
		wr(`ADDR_CTRL, 16'h0008);
		wait_st(ST_CMD_CAL, 5);
		wait_st(ST_CAL, 6 * SEC);
		chk("cal pulses", 16'h3, 16'(closes));
		closes = 0;
		conv_overtemp <= 1'b1;
		wait_st(ST_OFF, 5);
		repeat (4) @(posedge clk);
		chk("bias off", 16'h0, 16'(det_drive.high_voltage_bias));
		chk("cooler off", 16'h0, 16'(det_drive.peltier_on));
		chk("close sent", 16'h1, 16'(closes > 0));
		steps = 0;
		door_cmd_open <= 1'b1;
		door_cmd <= 1'b1;
		@(posedge clk);
		door_cmd <= 1'b0;
		repeat (12) @(posedge clk);
		chk("door dir", 16'h1, 16'(door_open_dir));
		repeat (60) @(posedge clk);
		chk("door steps", 16'h5, 16'(steps));
		op_mode <= 1'b0;
		conv_overtemp <= 1'b0;
		wr(`ADDR_CTRL, 16'h0001);
		op_mode <= 1'b1;
		repeat (10) @(posedge clk);
		chk("monitor off", 16'h0, 16'(seq_state));
		disabled_sensors <= 8'h11;
		repeat (6) @(posedge clk);
		chk("auto close", 16'h0, 16'(door_open_dir));
		finish_test();
	end
endmodule : tb
